// file: hw/tpu_timer.sv
// Function
// - in non-PWM modes a force strobe acts as a compare match on the output
// - a force strobe sets no flag and never clears the counter
// - the force strobe bit always reads back as zero
// - mode field picks normal, phase PWM, clear-on-match or fast PWM
// - nonzero output mode overrides port; pin driven only if direction out
// - non-PWM output modes: off, toggle, clear, set on match
// - fast PWM: off, reserved, clear match/set bottom, or inverse
// - fast PWM with compare at TOP and upper bit set ignores match
// - phase PWM: off, reserved, clear up set down, or the opposite
// - phase PWM with compare at TOP and upper bit set acts at TOP
// - clock select: stop, undivided, or divided by 8 to 1024
// - count register reads and writes the 8-bit counter directly
// - a count write suppresses the compare match on the next timer tick
// - compare value is compared continuously for flag and waveform
// - async select bit 3 picks system clock or crystal input
// - async count write sets busy bit 2 until counter is loaded
// - async compare write sets busy bit 1 until compare is loaded
// - async control write sets busy bit 0 until control is loaded
// - each async write commits after two crystal rising edges
// - count reads live counter; compare, control read holding registers
// - compare flag bit 7 set on match, cleared by vector or write one
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none

module tpu_timer
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  input  wire logic       crystalOscIn,
  input  wire logic       cmpVecAck,
  input  wire logic       ovfVecAck,
  input  wire logic       portDirOut,
  input  wire logic       portData,
  output logic            compareOutPin,
  output logic            compareOutEn_n,
  output logic            compareMatchFlag,
  output logic            overflowFlag
);

  // ****************************************************************
  // state
  // ****************************************************************
  tpu_pkg::tpu_ctrl_t                 ctrl_r;
  tpu_pkg::tpu_wgm_t                  mode;
  logic [tpu_pkg::HOLD_NUM-1:0][7:0]  hold_r;
  logic [tpu_pkg::HOLD_NUM-1:0][1:0]  edges_r;
  logic [tpu_pkg::HOLD_NUM-1:0][7:0]  commitData;
  logic [tpu_pkg::HOLD_NUM-1:0]       busy_r;
  logic [tpu_pkg::HOLD_NUM-1:0]       wrSel;
  logic [tpu_pkg::HOLD_NUM-1:0]       commit;
  logic [7:0]                         wrMasked;
  logic [7:0]                         cnt_r;
  logic [7:0]                         cmpBuf_r;
  logic [7:0]                         cmpAct_r;
  logic [7:0]                         top;
  logic [7:0]                         rdNxt;
  logic [7:0]                         rdData_r;
  logic [tpu_pkg::PRESC_W-1:0]        presc_r;
  logic                               asyncSel_r;
  logic                               xtalS1_r;
  logic                               xtalS2_r;
  logic                               xtalS3_r;
  logic                               xtalEdge;
  logic                               srcTick;
  logic                               timerTick;
  logic                               dirDown_r;
  logic                               blockMatch_r;
  logic                               match;
  logic                               atTopIgnore;
  logic                               forceHit;
  logic                               ovfSet;
  logic                               wrFlags;
  logic                               wrStatus;
  logic                               cmpFlag_r;
  logic                               ovfFlag_r;
  logic                               ocOut_r;
  tpu_pkg::tpu_ctrl_t                 wrCtrl;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ****************************************************************
  // timer clock source and prescaler
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      xtalS1_r <= 1'b0;
      xtalS2_r <= 1'b0;
      xtalS3_r <= 1'b0;
    end
    else
    begin
      xtalS1_r <= crystalOscIn;
      xtalS2_r <= xtalS1_r;
      xtalS3_r <= xtalS2_r;
    end
  end

  assign xtalEdge = xtalS2_r & ~xtalS3_r;
  assign srcTick  = asyncSel_r ? xtalEdge : 1'b1;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      presc_r <= '0;
    else if (srcTick)
      presc_r <= presc_r + 1'b1;
  end

  always_comb
  begin
    case (ctrl_r.cs)
      tpu_pkg::CS_STOP:  timerTick = 1'b0;
      tpu_pkg::CS_DIV1:  timerTick = srcTick;
      tpu_pkg::CS_DIV8:  timerTick = srcTick & (&presc_r[tpu_pkg::DIV8_W-1:0]);
      tpu_pkg::CS_DIV32: timerTick = srcTick & (&presc_r[tpu_pkg::DIV32_W-1:0]);
      tpu_pkg::CS_DIV64: timerTick = srcTick & (&presc_r[tpu_pkg::DIV64_W-1:0]);
      tpu_pkg::CS_D128:  timerTick = srcTick & (&presc_r[tpu_pkg::DIV128_W-1:0]);
      tpu_pkg::CS_D256:  timerTick = srcTick & (&presc_r[tpu_pkg::DIV256_W-1:0]);
      default:           timerTick = srcTick & (&presc_r[tpu_pkg::DIV1024_W-1:0]);
    endcase
  end

  // ****************************************************************
  // register writes, holding registers and update busy
  // ****************************************************************
  assign wrSel[tpu_pkg::HOLD_CTRL] = regWrEn && regAddr == tpu_pkg::ADDR_CONTROL;
  assign wrSel[tpu_pkg::HOLD_CMP]  = regWrEn && regAddr == tpu_pkg::ADDR_COMPARE;
  assign wrSel[tpu_pkg::HOLD_CNT]  = regWrEn && regAddr == tpu_pkg::ADDR_COUNT;
  assign wrStatus = regWrEn && regAddr == tpu_pkg::ADDR_STATUS;
  assign wrFlags  = regWrEn && regAddr == tpu_pkg::ADDR_FLAGS;
  assign wrMasked = regWrData & ~tpu_pkg::CTRL_FORCE_MASK;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      asyncSel_r <= 1'b0;
    else if (wrStatus)
      asyncSel_r <= regWrData[tpu_pkg::STATUS_ASYNC_BIT];
  end

  generate
    for (genvar i = 0; i < tpu_pkg::HOLD_NUM; i++)
    begin : gHold
      // sync mode loads the destination straight from the bus
      assign commit[i] = (wrSel[i] && !asyncSel_r) ||
                         (busy_r[i] && xtalEdge &&
                          edges_r[i] == tpu_pkg::COMMIT_LAST);
      assign commitData[i] = asyncSel_r ? hold_r[i] : regWrData;

      always_ff @(posedge ref_clk)
      begin
        if (rst)
          hold_r[i] <= tpu_pkg::RESET_BYTE;
        else if (wrSel[i])
          hold_r[i] <= (i == tpu_pkg::HOLD_CTRL) ? wrMasked : regWrData;
      end

      // a new write in the commit cycle keeps the slot busy
      always_ff @(posedge ref_clk)
      begin
        if (rst)
        begin
          busy_r[i]  <= 1'b0;
          edges_r[i] <= 2'h0;
        end
        else if (wrSel[i] && asyncSel_r)
        begin
          busy_r[i]  <= 1'b1;
          edges_r[i] <= 2'h0;
        end
        else if (busy_r[i] && xtalEdge)
        begin
          if (edges_r[i] == tpu_pkg::COMMIT_LAST)
            busy_r[i] <= 1'b0;
          edges_r[i] <= edges_r[i] + tpu_pkg::EDGE_STEP;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      ctrl_r <= tpu_pkg::RESET_BYTE;
    else if (commit[tpu_pkg::HOLD_CTRL])
      ctrl_r <= commitData[tpu_pkg::HOLD_CTRL] & ~tpu_pkg::CTRL_FORCE_MASK;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cmpBuf_r <= tpu_pkg::RESET_BYTE;
    else if (commit[tpu_pkg::HOLD_CMP])
      cmpBuf_r <= commitData[tpu_pkg::HOLD_CMP];
  end

  // ****************************************************************
  // counter and compare
  // ****************************************************************
  assign mode = tpu_pkg::tpu_wgm_t'({ctrl_r.wgmHi, ctrl_r.wgmLo});
  assign top  = (mode == tpu_pkg::WGM_CTC) ? cmpAct_r : tpu_pkg::COUNT_MAX;
  assign match = timerTick && cnt_r == cmpAct_r && !blockMatch_r;
  assign atTopIgnore = cmpAct_r == tpu_pkg::COUNT_MAX && ctrl_r.com[1];
  assign wrCtrl = regWrData;
  assign forceHit = wrSel[tpu_pkg::HOLD_CTRL] && wrCtrl.forceCmp &&
                    !wrCtrl.wgmLo;
  assign ovfSet = timerTick &&
                  ((mode == tpu_pkg::WGM_PHASE) ?
                   (dirDown_r && cnt_r == tpu_pkg::COUNT_BOTTOM) :
                   cnt_r == tpu_pkg::COUNT_MAX);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      blockMatch_r <= 1'b0;
    else if (commit[tpu_pkg::HOLD_CNT])
      blockMatch_r <= 1'b1;
    else if (timerTick)
      blockMatch_r <= 1'b0;
  end

  // force strobe never touches the counter
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cnt_r     <= tpu_pkg::COUNT_BOTTOM;
      dirDown_r <= 1'b0;
    end
    else if (commit[tpu_pkg::HOLD_CNT])
      cnt_r <= commitData[tpu_pkg::HOLD_CNT];
    else if (timerTick)
    begin
      if (mode == tpu_pkg::WGM_PHASE)
      begin
        if (!dirDown_r && cnt_r == top)
        begin
          dirDown_r <= 1'b1;
          cnt_r     <= cnt_r - tpu_pkg::COUNT_STEP;
        end
        else if (dirDown_r && cnt_r == tpu_pkg::COUNT_BOTTOM)
        begin
          dirDown_r <= 1'b0;
          cnt_r     <= cnt_r + tpu_pkg::COUNT_STEP;
        end
        else if (dirDown_r)
          cnt_r <= cnt_r - tpu_pkg::COUNT_STEP;
        else
          cnt_r <= cnt_r + tpu_pkg::COUNT_STEP;
      end
      else
      begin
        dirDown_r <= 1'b0;
        cnt_r <= (cnt_r == top) ? tpu_pkg::COUNT_BOTTOM :
                 cnt_r + tpu_pkg::COUNT_STEP;
      end
    end
  end

  // compare double buffer: immediate in normal and clear-on-match, at TOP in both PWM modes
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      cmpAct_r <= tpu_pkg::RESET_BYTE;
    else if (mode == tpu_pkg::WGM_NORMAL || mode == tpu_pkg::WGM_CTC)
      cmpAct_r <= cmpBuf_r;
    else if (timerTick && !dirDown_r && cnt_r == top)
      cmpAct_r <= cmpBuf_r;
  end

  // ****************************************************************
  // flags, set wins over clear
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cmpFlag_r <= 1'b0;
      ovfFlag_r <= 1'b0;
    end
    else
    begin
      cmpFlag_r <= match | (cmpFlag_r & ~(cmpVecAck |
                   (wrFlags & regWrData[tpu_pkg::FLAG_CMP_BIT])));
      ovfFlag_r <= ovfSet | (ovfFlag_r & ~(ovfVecAck |
                   (wrFlags & regWrData[tpu_pkg::FLAG_OVF_BIT])));
    end
  end

  // ****************************************************************
  // waveform output
  // ****************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      ocOut_r <= 1'b0;
    else if (forceHit)
    begin
      if (wrCtrl.com == tpu_pkg::COM_TOGGLE)
        ocOut_r <= ~ocOut_r;
      else if (wrCtrl.com[1])
        ocOut_r <= wrCtrl.com[0];
    end
    else if (timerTick)
    begin
      case (mode)
        tpu_pkg::WGM_FAST:
        begin
          if (ctrl_r.com[1] && cnt_r == top)
            ocOut_r <= ~ctrl_r.com[0];
          else if (ctrl_r.com[1] && match && !atTopIgnore)
            ocOut_r <= ctrl_r.com[0];
        end
        tpu_pkg::WGM_PHASE:
        begin
          if (ctrl_r.com[1] && atTopIgnore)
          begin
            if (!dirDown_r && cnt_r == top)
              ocOut_r <= ctrl_r.com[0];
          end
          else if (ctrl_r.com[1] && match)
            ocOut_r <= ctrl_r.com[0] ^ dirDown_r;
        end
        default:
        begin
          if (match && ctrl_r.com == tpu_pkg::COM_TOGGLE)
            ocOut_r <= ~ocOut_r;
          else if (match && ctrl_r.com[1])
            ocOut_r <= ctrl_r.com[0];
        end
      endcase
    end
  end

  assign compareOutPin  = (ctrl_r.com != tpu_pkg::COM_OFF) ?
                          ocOut_r : portData;
  assign compareOutEn_n = ~portDirOut;
  assign compareMatchFlag = cmpFlag_r;
  assign overflowFlag     = ovfFlag_r;

  // ****************************************************************
  // register reads
  // ****************************************************************
  always_comb
  begin
    if (regAddr == tpu_pkg::ADDR_CONTROL)
      rdNxt = hold_r[tpu_pkg::HOLD_CTRL];
    else if (regAddr == tpu_pkg::ADDR_COUNT)
      rdNxt = cnt_r;
    else if (regAddr == tpu_pkg::ADDR_COMPARE)
      rdNxt = hold_r[tpu_pkg::HOLD_CMP];
    else if (regAddr == tpu_pkg::ADDR_STATUS)
      rdNxt = {tpu_pkg::STATUS_PAD, asyncSel_r, busy_r};
    else if (regAddr == tpu_pkg::ADDR_FLAGS)
      rdNxt = {cmpFlag_r, ovfFlag_r, 6'h00};
    else
      rdNxt = tpu_pkg::RESET_BYTE;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      rdData_r <= tpu_pkg::RESET_BYTE;
    else
      rdData_r <= regRdEn ? rdNxt : tpu_pkg::RESET_BYTE;
  end

  assign regRdData = rdData_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence cmpWrAsync;
    wrSel[tpu_pkg::HOLD_CMP] && asyncSel_r;
  endsequence

  sequence firstEdgeOnly;
    xtalEdge && !wrSel[tpu_pkg::HOLD_CMP];
  endsequence

  a_force_no_flag: assert property (forceHit && !match |=> !$rose(cmpFlag_r))
    else $error("force strobe raised the compare flag");
  a_ctrl_read_zero: assert property (regRdEn && regAddr == tpu_pkg::ADDR_CONTROL
    |=> !regRdData[7])
    else $error("force bit read as one");
  a_load_blocks: assert property (commit[tpu_pkg::HOLD_CNT] |=> blockMatch_r)
    else $error("count write did not block next match");
  a_match_flag: assert property (match |=> cmpFlag_r)
    else $error("match did not set compare flag");
  a_flag_clear: assert property (cmpFlag_r && cmpVecAck && !match |=> !cmpFlag_r)
    else $error("vector ack did not clear compare flag");
  a_cnt_busy: assert property (wrSel[tpu_pkg::HOLD_CNT] && asyncSel_r
    |=> busy_r[tpu_pkg::HOLD_CNT])
    else $error("async count write did not set busy");
  a_cmp_first_edge: assert property (cmpWrAsync ##1 firstEdgeOnly
    |=> busy_r[tpu_pkg::HOLD_CMP])
    else $error("compare committed after one edge");
  a_ctrl_busy_fall: assert property ($fell(busy_r[tpu_pkg::HOLD_CTRL])
    |-> $past(xtalEdge))
    else $error("control busy cleared without crystal edge");
  a_ctc_clear: assert property (timerTick && mode == tpu_pkg::WGM_CTC &&
    cnt_r == top && !commit[tpu_pkg::HOLD_CNT] |=> cnt_r == 8'h00)
    else $error("clear-on-match did not wrap to zero");
  a_phase_turn: assert property (timerTick && mode == tpu_pkg::WGM_PHASE &&
    !dirDown_r && cnt_r == 8'hFF && !commit[tpu_pkg::HOLD_CNT]
    |=> dirDown_r && cnt_r == 8'hFE)
    else $error("phase mode did not turn at top");
  a_stop_holds: assert property (ctrl_r.cs == tpu_pkg::CS_STOP &&
    !commit[tpu_pkg::HOLD_CNT] |=> cnt_r == $past(cnt_r))
    else $error("stopped counter moved");
  a_toggle_match: assert property (match && !forceHit &&
    mode == tpu_pkg::WGM_NORMAL && ctrl_r.com == tpu_pkg::COM_TOGGLE
    |=> ocOut_r != $past(ocOut_r))
    else $error("toggle mode did not toggle on match");

endmodule

`default_nettype wire

// file: hw/tpu_pkg.sv
package tpu_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_COUNT   = 3'h1;
  localparam logic [2:0] ADDR_COMPARE = 3'h2;
  localparam logic [2:0] ADDR_STATUS  = 3'h3;
  localparam logic [2:0] ADDR_FLAGS   = 3'h4;

  localparam int STATUS_ASYNC_BIT = 3;
  localparam int FLAG_CMP_BIT     = 7;
  localparam int FLAG_OVF_BIT     = 6;

  localparam logic [7:0] CTRL_FORCE_MASK = 8'h80;
  localparam logic [7:0] RESET_BYTE      = 8'h00;
  localparam logic [3:0] STATUS_PAD      = 4'h0;

  // holding register slots, index equals busy bit position in status
  localparam int HOLD_CTRL = 0;
  localparam int HOLD_CMP  = 1;
  localparam int HOLD_CNT  = 2;
  localparam int HOLD_NUM  = 3;

  // ****************************************************************
  // counter and prescaler constants
  // ****************************************************************
  localparam logic [7:0] COUNT_MAX    = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_STEP   = 8'h01;
  localparam logic [1:0] COMMIT_LAST  = 2'h1;
  localparam logic [1:0] EDGE_STEP    = 2'h1;
  localparam int PRESC_W   = 10;
  localparam int DIV8_W    = 3;
  localparam int DIV32_W   = 5;
  localparam int DIV64_W   = 6;
  localparam int DIV128_W  = 7;
  localparam int DIV256_W  = 8;
  localparam int DIV1024_W = 10;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    WGM_NORMAL = 2'b00,
    WGM_PHASE  = 2'b01,
    WGM_CTC    = 2'b10,
    WGM_FAST   = 2'b11
  } tpu_wgm_t;

  typedef enum logic [1:0] {
    COM_OFF    = 2'b00,
    COM_TOGGLE = 2'b01,
    COM_CLEAR  = 2'b10,
    COM_SET    = 2'b11
  } tpu_com_t;

  typedef enum logic [2:0] {
    CS_STOP  = 3'b000,
    CS_DIV1  = 3'b001,
    CS_DIV8  = 3'b010,
    CS_DIV32 = 3'b011,
    CS_DIV64 = 3'b100,
    CS_D128  = 3'b101,
    CS_D256  = 3'b110,
    CS_D1024 = 3'b111
  } tpu_cs_t;

  typedef struct packed {
    logic       forceCmp;
    logic       wgmHi;
    logic [1:0] com;
    logic       wgmLo;
    logic [2:0] cs;
  } tpu_ctrl_t;

endpackage

// file: sim/async_timer_pwm_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none

module async_timer_pwm_unit_tb;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic       ref_clk;
  logic       rst;
  logic [2:0] regAddr;
  logic [7:0] regWrData;
  logic       regWrEn;
  logic       regRdEn;
  logic [7:0] regRdData;
  logic       crystalOscIn;
  logic       portDirOut;
  logic       portData;
  logic       compareOutPin;
  logic       compareOutEn_n;
  logic       compareMatchFlag;
  logic       overflowFlag;
  logic       cmpVecAck;
  logic       ovfVecAck;
  logic       rdSeen;
  logic       bitChk;
  logic [7:0] rdQ[$];
  logic [2:0] bitQ[$];
  logic [2:0] bitNote;
  logic [7:0] rv;
  int         err_count;
  int         checks;
  logic [7:0] ctlTab[6] = '{8'h90, 8'hA0, 8'hB0, 8'hD0, 8'hE0, 8'hF0};
  logic [5:0] pinTab    = 6'h25;

  tpu_timer dut_u
  (
    .ref_clk          (ref_clk),
    .rst              (rst),
    .regAddr          (regAddr),
    .regWrData        (regWrData),
    .regWrEn          (regWrEn),
    .regRdEn          (regRdEn),
    .regRdData        (regRdData),
    .crystalOscIn     (crystalOscIn),
    .cmpVecAck        (cmpVecAck),
    .ovfVecAck        (ovfVecAck),
    .portDirOut       (portDirOut),
    .portData         (portData),
    .compareOutPin    (compareOutPin),
    .compareOutEn_n   (compareOutEn_n),
    .compareMatchFlag (compareMatchFlag),
    .overflowFlag     (overflowFlag)
  );

  // ****************************************************************
  // compare and report
  // ****************************************************************
  task automatic cmp8(input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic cmp1(input logic e, input logic g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************************************************************
  // bus and pin tasks
  // ****************************************************************
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrEn   <= 1'b1;
    @(posedge ref_clk);
    regWrEn   <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    rdQ.push_back(e);
    @(posedge ref_clk);
    regRdEn <= 1'b0;
  endtask

  // sel 0 pin, 1 compare flag, 2 output enable, 3 overflow flag
  task automatic chk_bit(input logic [1:0] sel, input logic e);
    @(posedge ref_clk);
    bitQ.push_back({sel, e});
    bitChk <= 1'b1;
    @(posedge ref_clk);
    bitChk <= 1'b0;
  endtask

  // one crystal period, level stands still afterwards
  task automatic xtal_edge;
    repeat (6) @(posedge ref_clk);
    crystalOscIn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    crystalOscIn <= 1'b0;
  endtask

  // ****************************************************************
  // output monitor
  // ****************************************************************
  always @(posedge ref_clk)
    rdSeen <= regRdEn;

  always @(negedge ref_clk)
  begin
    if (rdSeen)
      cmp8(rdQ.pop_front(), regRdData);
    if (bitChk)
    begin
      bitNote = bitQ.pop_front();
      if (bitNote[2:1] == 2'd0)
        cmp1(bitNote[0], compareOutPin);
      else if (bitNote[2:1] == 2'd1)
        cmp1(bitNote[0], compareMatchFlag);
      else if (bitNote[2:1] == 2'd2)
        cmp1(bitNote[0], compareOutEn_n);
      else
        cmp1(bitNote[0], overflowFlag);
    end
  end

  // ****************************************************************
  // clock and watchdog
  // ****************************************************************
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial
  begin
    #100000;
    err_count++;
    stop_test();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    rst = 1'b1;
    regAddr = 3'h0;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    crystalOscIn = 1'b0;
    portDirOut = 1'b1;
    portData = 1'b0;
    bitChk = 1'b0;
    cmpVecAck = 1'b0;
    ovfVecAck = 1'b0;
    err_count = 0;
    checks = 0;
    rv = 8'($urandom(58714));
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rd(tpu_pkg::ADDR_STATUS, 8'h00);
    rd(tpu_pkg::ADDR_CONTROL, 8'h00);
    rd(tpu_pkg::ADDR_FLAGS, 8'h00);
    rd(3'h5, 8'h00);
    $display("test reset done");

    for (int i = 0; i < 6; i++)
    begin
      wr(tpu_pkg::ADDR_CONTROL, ctlTab[i]);
      chk_bit(2'd0, pinTab[i]);
    end
    chk_bit(2'd1, 1'b0);
    rd(tpu_pkg::ADDR_CONTROL, 8'h70);
    rd(tpu_pkg::ADDR_COUNT, 8'h00);
    wr(tpu_pkg::ADDR_CONTROL, 8'h78);
    chk_bit(2'd0, 1'b1);
    rd(tpu_pkg::ADDR_CONTROL, 8'h78);
    $display("test force strobe done");

    wr(tpu_pkg::ADDR_CONTROL, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      rv = 8'($urandom());
      @(posedge ref_clk);
      portData <= rv[0];
      portDirOut <= rv[1];
      chk_bit(2'd0, rv[0]);
      chk_bit(2'd2, ~rv[1]);
    end
    $display("test port override done");

    rv = 8'($urandom());
    wr(tpu_pkg::ADDR_COUNT, rv);
    rd(tpu_pkg::ADDR_COUNT, rv);
    wr(tpu_pkg::ADDR_COMPARE, ~rv);
    rd(tpu_pkg::ADDR_COMPARE, ~rv);
    $display("test count compare access done");

    wr(tpu_pkg::ADDR_COUNT, 8'h00);
    wr(tpu_pkg::ADDR_COMPARE, 8'h05);
    wr(tpu_pkg::ADDR_CONTROL, 8'h01);
    for (int i = 0; i < 20 && compareMatchFlag !== 1'b1; i++)
      @(posedge ref_clk);
    chk_bit(2'd1, 1'b1);
    wr(tpu_pkg::ADDR_CONTROL, 8'h00);
    rd(tpu_pkg::ADDR_FLAGS, 8'h80);
    wr(tpu_pkg::ADDR_FLAGS, 8'h80);
    rd(tpu_pkg::ADDR_FLAGS, 8'h00);
    $display("test compare match done");

    wr(tpu_pkg::ADDR_COUNT, 8'hFD);
    wr(tpu_pkg::ADDR_CONTROL, 8'h01);
    repeat (12) @(posedge ref_clk);
    wr(tpu_pkg::ADDR_CONTROL, 8'h00);
    chk_bit(2'd3, 1'b1);
    chk_bit(2'd1, 1'b1);
    @(posedge ref_clk);
    cmpVecAck <= 1'b1;
    ovfVecAck <= 1'b1;
    @(posedge ref_clk);
    cmpVecAck <= 1'b0;
    ovfVecAck <= 1'b0;
    chk_bit(2'd3, 1'b0);
    chk_bit(2'd1, 1'b0);
    $display("test overflow and vector clear done");

    wr(tpu_pkg::ADDR_CONTROL, 8'h01);
    wr(tpu_pkg::ADDR_COUNT, 8'h05);
    wr(tpu_pkg::ADDR_CONTROL, 8'h00);
    chk_bit(2'd1, 1'b0);
    rd(tpu_pkg::ADDR_COUNT, 8'h07);
    $display("test match suppression done");

    wr(tpu_pkg::ADDR_COMPARE, 8'hF0);
    wr(tpu_pkg::ADDR_COUNT, 8'hFD);
    wr(tpu_pkg::ADDR_CONTROL, 8'h39);
    repeat (20) @(posedge ref_clk);
    wr(tpu_pkg::ADDR_CONTROL, 8'h30);
    chk_bit(2'd0, 1'b0);
    rd(tpu_pkg::ADDR_COUNT, 8'hEB);
    $display("test phase pwm done");

    wr(tpu_pkg::ADDR_STATUS, 8'h08);
    rd(tpu_pkg::ADDR_STATUS, 8'h08);
    // all three registers rewritten after the source switch
    wr(tpu_pkg::ADDR_COMPARE, 8'h55);
    wr(tpu_pkg::ADDR_COUNT, 8'h11);
    wr(tpu_pkg::ADDR_CONTROL, 8'h00);
    rd(tpu_pkg::ADDR_STATUS, 8'h0F);
    xtal_edge();
    rd(tpu_pkg::ADDR_STATUS, 8'h0F);
    xtal_edge();
    repeat (4) @(posedge ref_clk);
    rd(tpu_pkg::ADDR_STATUS, 8'h08);
    rd(tpu_pkg::ADDR_COMPARE, 8'h55);
    rd(tpu_pkg::ADDR_COUNT, 8'h11);
    $display("test async update done");

    repeat (4) @(posedge ref_clk);
    stop_test();
  end

endmodule

`default_nettype wire
